// >>> logic/cogp_map.svh
// register offsets, field positions, reset values and timings in ns for clock output control
`ifndef COGP_MAP_SVH
`define COGP_MAP_SVH

`define COGP_ADDR_OE       4'h0
`define COGP_ADDR_SPREAD   4'h1
`define COGP_ADDR_STATUS   4'h2

`define COGP_OE_RST        9'h1FF
`define COGP_SPREAD_RST    4'h2

`define COGP_SE_REF        0
`define COGP_SE_USB        1
`define COGP_SE_VID_NSS    2
`define COGP_SE_VID_SS     3
`define COGP_DIF_BASE      4
`define COGP_NUM_OUT       9
`define COGP_NUM_SE        4

`define COGP_CLK_NS        25
`define COGP_STABLE_NS     1800000

`endif

// >>> logic/cogp_pkg.sv
// types shared by the clock output control block
package cogp_pkg;

  typedef enum logic [4:0]
  {
    COGP_WAIT_PG = 5'h01,
    COGP_START   = 5'h02,
    COGP_RUN     = 5'h04,
    COGP_STOP    = 5'h08,
    COGP_OFF     = 5'h10
  } cogp_state_type;

  // spread profile handed to the modulator; depth in steps of 0.25 %
  typedef struct packed
  {
    logic       valid;
    logic       centre;
    logic [3:0] depth_qtr;
  } cogp_spread_type;

endpackage

// >>> logic/cogp_sync2.sv
// two-flop synchroniser for the asynchronous control pins
`timescale 1ns/100ps

module cogp_sync2
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] async_in,
  output logic      [2:0] sync_out
);

  logic [2:0] meta_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_r   <= 3'h0;
      sync_out <= 3'h0;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> logic/cogp_gate.sv
// glitch-free per-output enable, changed only at the output's falling edge
`timescale 1ns/100ps

module cogp_gate
(
  input  wire logic sys_clk_in,
  input  wire logic rst_n_in,
  input  wire logic fall_tick_in,
  input  wire logic want_in,
  output logic      en_out
);

  // updating only while the clock sits low means no short or long pulse
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      en_out <= 1'b0;
    else if (fall_tick_in)
      en_out <= want_in;
  end

endmodule

// >>> logic/cogp_top.sv
// output gating, video stop and power-down sequencing of the clock generator
`timescale 1ns/100ps
`include "cogp_map.svh"

// Overview of operation
// RULE1: codes 0010-1000 select the listed down-spread depths
// RULE2: 1001/1010 centre spread, other codes invalid
// RULE3: video enable pin stops only video clocks
// RULE4: cleared enable bit drives that output low
// RULE5: power-down: single-ended low or hi-z, differentials low
// RULE6: shared pin is power-good, then power-down request
// RULE7: power-down pin synchronised before use
// RULE8: clocks low first, then oscillators off
// RULE9: two low CPU-edge samples, stop at falling edge
// RULE10: host pulls pin low within 10 us
// RULE11: stable clocks within 1.8 ms of release
// RULE12: stopped differentials driven high on release
// RULE13: outputs enabled within few own cycles after lock
// RULE14: video pin stops both video clocks together
// RULE15: video stop after two falling-edge samples, rest low
// RULE16: video restart within two cycles, no runt
// RULE17: shared pin ignored until power-good seen
module cogp_top
#(
  parameter int STABLE_CYC = `COGP_STABLE_NS / `COGP_CLK_NS
)
(
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [3:0]               reg_addr_in,
  input  wire logic [15:0]              reg_wdata_in,
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  output logic      [15:0]              reg_rdata_out,
  input  wire logic                     pwrgd_pd_n_in,
  input  wire logic                     video_out_enable_n_in,
  input  wire logic                     strap_in,
  output logic      [`COGP_NUM_SE-1:0]  se_clk_out,
  output logic      [`COGP_NUM_SE-1:0]  se_oe_out,
  output logic      [4:0]               diff_true_out,
  output logic      [4:0]               diff_comp_out,
  output logic                          osc_on_out,
  output logic                          pll_locked_out,
  output cogp_pkg::cogp_spread_type     spread_out
);

  cogp_pkg::cogp_state_type      state_r;
  cogp_pkg::cogp_state_type      state_nxt;
  logic [2:0]                    pin_sync;
  logic [8:0]                    oe_r;
  logic [3:0]                    spread_sel_r;
  logic [3:0]                    cnt_r;
  logic [8:0]                    phase;
  logic [8:0]                    phase_d_r;
  logic [8:0]                    fall_tick;
  logic [8:0]                    want;
  logic [8:0]                    gate_en;
  logic                          cpu_rise;
  logic [1:0]                    pd_samp_r;
  logic [1:0]                    vid_samp_r;
  logic                          pd_req;
  logic                          vid_run;
  logic [16:0]                   timer_r;
  logic                          strap_r;
  logic [1:0]                    strap_age_r;
  cogp_pkg::cogp_spread_type     spread_nxt;

  // pin 0 shared power-good / power-down, 1 video enable, 2 strap
  cogp_sync2 u_sync
  (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({strap_in, video_out_enable_n_in, pwrgd_pd_n_in}),
    .sync_out   (pin_sync)
  ); // RULE7

  // ************************************************************
  // register port
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      oe_r         <= `COGP_OE_RST;
      spread_sel_r <= `COGP_SPREAD_RST;
    end
    else if (reg_wr_in && reg_addr_in == `COGP_ADDR_OE)
      oe_r <= reg_wdata_in[8:0];
    else if (reg_wr_in && reg_addr_in == `COGP_ADDR_SPREAD)
      spread_sel_r <= reg_wdata_in[3:0];
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 16'h0000;
    else
      case (reg_rd_in ? reg_addr_in : 4'hF) // unmapped index F: no read returns 0
        `COGP_ADDR_OE:     reg_rdata_out <= {7'h00, oe_r};
        `COGP_ADDR_SPREAD: reg_rdata_out <= {12'h000, spread_sel_r};
        `COGP_ADDR_STATUS: reg_rdata_out <= {8'h00, state_r, strap_r, pll_locked_out,
                                             ~spread_out.valid};
        default:           reg_rdata_out <= 16'h0000;
      endcase
  end

  // ************************************************************
  // spread profile decode
  // ************************************************************
  always_comb
  begin
    spread_nxt = '{valid: 1'b1, centre: 1'b0, depth_qtr: 4'h0};
    case (spread_sel_r)
      4'h2:    spread_nxt.depth_qtr = 4'h2; // RULE1
      4'h3:    spread_nxt.depth_qtr = 4'h4; // RULE1
      4'h4:    spread_nxt.depth_qtr = 4'h6; // RULE1
      4'h5:    spread_nxt.depth_qtr = 4'h8; // RULE1
      4'h6:    spread_nxt.depth_qtr = 4'h3; // RULE1
      4'h7:    spread_nxt.depth_qtr = 4'h5; // RULE1
      4'h8:    spread_nxt.depth_qtr = 4'h7; // RULE1
      4'h9:    spread_nxt = '{valid: 1'b1, centre: 1'b1, depth_qtr: 4'h2}; // RULE2
      4'hA:    spread_nxt = '{valid: 1'b1, centre: 1'b1, depth_qtr: 4'h3}; // RULE2
      default: spread_nxt = '{valid: 1'b0, centre: 1'b0, depth_qtr: 4'h0}; // RULE2
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      spread_out <= '{valid: 1'b0, centre: 1'b0, depth_qtr: 4'h0};
    else
      spread_out <= spread_nxt;
  end

  // ************************************************************
  // internal clock phases
  // ************************************************************
  // synthesised phases stand in for the real PLL outputs at reduced rates
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r     <= 4'h0;
      phase_d_r <= 9'h000;
    end
    else
    begin
      cnt_r     <= cnt_r + 4'h1;
      phase_d_r <= phase;
    end
  end

  assign phase     = {{5{cnt_r[1]}}, cnt_r[2], cnt_r[2], cnt_r[2], cnt_r[3]};
  assign fall_tick = phase_d_r & ~phase;
  assign cpu_rise  = phase[`COGP_DIF_BASE] & ~phase_d_r[`COGP_DIF_BASE];

  // ************************************************************
  // pin sampling
  // ************************************************************
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pd_samp_r <= 2'h3;
    else if (state_r == cogp_pkg::COGP_WAIT_PG)
      pd_samp_r <= 2'h3; // RULE17
    else if (cpu_rise)
      pd_samp_r <= {pd_samp_r[0], pin_sync[0]};
  end

  assign pd_req = (pd_samp_r == 2'h0); // RULE9

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      vid_samp_r <= 2'h0;
    else if (fall_tick[`COGP_SE_VID_SS])
      vid_samp_r <= {vid_samp_r[0], ~pin_sync[1]};
  end

  // one released sample restarts, so the restart lands within two cycles
  assign vid_run = ~vid_samp_r[0] | ~vid_samp_r[1]; // RULE15 RULE16

  // strap caught at third edge: the synchroniser shows its reset value before
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_r     <= 1'b0;
      strap_age_r <= 2'h0;
    end
    else if (strap_age_r != 2'h3)
    begin
      strap_age_r <= strap_age_r + 2'h1;
      if (strap_age_r == 2'h2)
        strap_r <= pin_sync[2];
    end
  end

  // ************************************************************
  // power sequencing
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      cogp_pkg::COGP_WAIT_PG:
        if (pin_sync[0])
          state_nxt = cogp_pkg::COGP_START; // RULE6 RULE17
      cogp_pkg::COGP_START:
        if (pd_req)
          state_nxt = cogp_pkg::COGP_STOP;
        else if (timer_r == 17'(STABLE_CYC - 1))
          state_nxt = cogp_pkg::COGP_RUN; // RULE11
      cogp_pkg::COGP_RUN:
        if (pd_req)
          state_nxt = cogp_pkg::COGP_STOP; // RULE9
      cogp_pkg::COGP_STOP:
        if (gate_en == 9'h000)
          state_nxt = cogp_pkg::COGP_OFF; // RULE8
      cogp_pkg::COGP_OFF:
        if (pd_samp_r[0])
          state_nxt = cogp_pkg::COGP_START; // RULE7
      default:
        state_nxt = cogp_pkg::COGP_WAIT_PG;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_r <= cogp_pkg::COGP_WAIT_PG;
    else
      state_r <= state_nxt;
  end

  // lock timer runs only while the synthesiser is starting
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      timer_r <= 17'h00000;
    else
      timer_r <= (state_r == cogp_pkg::COGP_START) ? timer_r + 17'h00001 : 17'h00000;
  end

  // ************************************************************
  // output gating
  // ************************************************************
  for (genvar gi = 0; gi < `COGP_NUM_OUT; gi++)
  begin : g_out
    assign want[gi] = (state_r == cogp_pkg::COGP_RUN) & oe_r[gi] // RULE4
      & (vid_run | (gi != `COGP_SE_VID_SS && gi != `COGP_SE_VID_NSS)); // RULE3 RULE14
    cogp_gate u_gate
    (
      .sys_clk_in   (sys_clk_in),
      .rst_n_in     (rst_n_in),
      .fall_tick_in (fall_tick[gi]),
      .want_in      (want[gi]),
      .en_out       (gate_en[gi])
    ); // RULE13
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      se_clk_out    <= 4'h0;
      se_oe_out     <= 4'hF;
      diff_true_out <= 5'h00;
      diff_comp_out <= 5'h00;
    end
    else
    begin
      se_clk_out <= phase[3:0] & gate_en[3:0]; // RULE9
      se_oe_out  <= {4{~(strap_r && state_r == cogp_pkg::COGP_OFF)}}; // RULE5
      diff_true_out <= (state_r == cogp_pkg::COGP_START) ? 5'h1F // RULE12
        : (state_r == cogp_pkg::COGP_RUN) ? phase[8:4] & gate_en[8:4] : 5'h00; // RULE5 RULE8
      diff_comp_out <= (state_r == cogp_pkg::COGP_RUN) ? ~phase[8:4] & gate_en[8:4] : 5'h00;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      osc_on_out     <= 1'b1;
      pll_locked_out <= 1'b0;
    end
    else
    begin
      osc_on_out     <= (state_r != cogp_pkg::COGP_OFF); // RULE8
      pll_locked_out <= (state_r == cogp_pkg::COGP_RUN);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  spread_down_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE1
    spread_sel_r == 4'h4 |=> spread_out.valid && !spread_out.centre
      && spread_out.depth_qtr == 4'h6)
    else $error("down-spread code decoded wrong");
  spread_invalid_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE2
    (spread_sel_r < 4'h2 || spread_sel_r > 4'hA) |=> !spread_out.valid)
    else $error("invalid spread code accepted");
  other_clk_run_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE3
    (state_r == cogp_pkg::COGP_RUN && oe_r[1] && fall_tick[1]) |=> gate_en[1])
    else $error("non-video clock stopped while running");
  oe_clear_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE4
    (!oe_r[0] && !gate_en[0]) |=> !se_clk_out[0])
    else $error("disabled output not low");
  pd_strap_hiz_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE5
    (state_r == cogp_pkg::COGP_OFF) |=> se_oe_out == {4{~strap_r}}
      && diff_true_out == 5'h00 && diff_comp_out == 5'h00)
    else $error("power-down output state wrong");
  pg_ignore_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE17
    (state_r == cogp_pkg::COGP_WAIT_PG) |=> state_r != cogp_pkg::COGP_STOP && !pd_req
      && se_clk_out == 4'h0)
    else $error("shared pin acted on before power-good");
  pd_two_samp_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE9
    (state_r == cogp_pkg::COGP_RUN && $changed(state_r) == 1'b0
      && state_nxt == cogp_pkg::COGP_STOP) |-> pd_samp_r == 2'h0)
    else $error("power-down taken without two low samples");
  stop_order_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE8
    (state_r == cogp_pkg::COGP_STOP) |=> osc_on_out && diff_true_out == 5'h00)
    else $error("oscillator stopped before clocks held low");
  vid_stop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE15
    (vid_samp_r == 2'h3 && fall_tick[`COGP_SE_VID_SS])
      |=> !gate_en[`COGP_SE_VID_SS] && !gate_en[`COGP_SE_VID_NSS])
    else $error("video clocks not stopped after two samples");
  vid_together_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE14
    (oe_r[3:2] == 2'h3 && fall_tick[`COGP_SE_VID_SS])
      |=> gate_en[`COGP_SE_VID_SS] == gate_en[`COGP_SE_VID_NSS])
    else $error("video clocks gated apart");
  start_bias_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RULE12
    (state_r == cogp_pkg::COGP_START) |=> diff_true_out == 5'h1F)
    else $error("differentials not driven high on release");
endmodule

// >>> tb/cogp_pm_model.sv
// power-management model driving the shared power pin and the video stop pin
`timescale 1ns/100ps

module cogp_pm_model
(
  input  wire logic       sys_clk_in,
  input  wire logic       pg_in,
  input  wire logic       pd_req_in,
  input  wire logic       vid_stop_in,
  input  wire logic [7:0] lag_in,
  output logic            pwrgd_pd_n_out,
  output logic            video_out_enable_n_out
);
  logic [7:0] wait_r;
  logic       want;

  // pin is low until power is good, then it carries the power-down request
  assign want = pg_in & ~pd_req_in;

  initial
  begin
    pwrgd_pd_n_out = 1'b0;
    video_out_enable_n_out = 1'b1;
    wait_r = 8'h00;
  end

  // lag below 256 cycles keeps a requested power-down inside 10 us of the request
  always @(posedge sys_clk_in)
  begin
    video_out_enable_n_out <= ~vid_stop_in;
    if (want == pwrgd_pd_n_out)
      wait_r <= 8'h00;
    else if (wait_r >= lag_in)
    begin
      pwrgd_pd_n_out <= want;
      wait_r <= 8'h00;
    end
    else
      wait_r <= wait_r + 8'h01;
  end
endmodule

// >>> tb/tb.sv
// self-checking bench for the clock output control block
`timescale 1ns/100ps

module tb;
  localparam int STABLE = 20;
  logic                      sys_clk_in;
  logic                      rst_n_in;
  logic [3:0]                reg_addr_in;
  logic [15:0]               reg_wdata_in;
  logic                      reg_wr_in;
  logic                      reg_rd_in;
  logic [15:0]               reg_rdata_out;
  logic                      pwrgd_pd_n_in;
  logic                      video_out_enable_n_in;
  logic                      strap_in;
  logic [3:0]                se_clk_out;
  logic [3:0]                se_oe_out;
  logic [4:0]                diff_true_out;
  logic [4:0]                diff_comp_out;
  logic                      osc_on_out;
  logic                      pll_locked_out;
  cogp_pkg::cogp_spread_type spread_out;
  logic                      pg;
  logic                      pd_req;
  logic                      vid_stop;
  logic [7:0]                lag;
  logic [8:0]                seen;
  logic                      clr;
  logic [15:0]               rv;
  logic [8:0]                oe;
  logic [5:0]                e;
  logic [3:0]                ofs;
  int                        error_cnt;
  int                        check_count;
  int                        cyc;
  int                        n;

  cogp_top #(.STABLE_CYC(STABLE)) DUT (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pwrgd_pd_n_in(pwrgd_pd_n_in),
    .video_out_enable_n_in(video_out_enable_n_in), .strap_in(strap_in),
    .se_clk_out(se_clk_out), .se_oe_out(se_oe_out), .diff_true_out(diff_true_out),
    .diff_comp_out(diff_comp_out), .osc_on_out(osc_on_out),
    .pll_locked_out(pll_locked_out), .spread_out(spread_out));

  cogp_pm_model PM (.sys_clk_in(sys_clk_in), .pg_in(pg), .pd_req_in(pd_req),
    .vid_stop_in(vid_stop), .lag_in(lag), .pwrgd_pd_n_out(pwrgd_pd_n_in),
    .video_out_enable_n_out(video_out_enable_n_in));

  // ************************
  // clock, watchdog, monitor
  // ************************
  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // outputs that went high at least once since the last clear
  always @(posedge sys_clk_in)
  begin
    seen <= clr ? 9'h000 : (seen | {diff_true_out, se_clk_out});
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ************************
  // tasks and expectations
  // ************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic watch(input int len);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    repeat (len) @(posedge sys_clk_in);
    #1;
  endtask

  // strap must hold for three edges after release
  // lag cleared so the shared pin falls with power-good inside the reset
  task automatic reset(input logic s);
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    lag <= 8'h00;
    pg <= 1'b0;
    pd_req <= 1'b0;
    strap_in <= s;
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic lock_up();
    for (n = 0; n < STABLE + 60 && pll_locked_out !== 1'b1; n++) @(posedge sys_clk_in);
  endtask

  task automatic power_down();
    pd_req <= 1'b1;
    for (n = 0; n < 400 && osc_on_out !== 1'b0; n++) @(posedge sys_clk_in);
  endtask

  // valid, centre, depth in quarter percent
  function automatic logic [5:0] exp_spread(input logic [3:0] c);
    case (c)
      4'h2: return 6'h22;
      4'h3: return 6'h24;
      4'h4: return 6'h26;
      4'h5: return 6'h28;
      4'h6: return 6'h23;
      4'h7: return 6'h25;
      4'h8: return 6'h27;
      4'h9: return 6'h32;
      4'hA: return 6'h33;
      default: return 6'h00;
    endcase
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************
  // main sequence
  // ************************
  initial
  begin
    {rst_n_in, reg_wr_in, reg_rd_in, pg, pd_req, vid_stop, strap_in, clr} = 8'h00;
    {reg_addr_in, reg_wdata_in, lag, error_cnt, check_count, cyc} = '0;
    void'($urandom(32'hB3C4));
    reset(1'b0);
    // shared pin held low before power-good must not count as power-down
    repeat (30) @(posedge sys_clk_in);
    rd(4'h0, rv);
    chk(rv, 16'h01FF);
    rd(4'h1, rv);
    chk(rv, 16'h0002);
    rd(4'h2, rv);
    chk(rv, 16'h0008);
    wr(4'h3, 16'hFFFF);
    rd(4'h3, rv);
    chk(rv, 16'h0000);
    $display("test reset_values done");
    ofs = 4'($urandom);
    for (int i = 0; i < 16; i++)
    begin
      wr(4'h1, 16'(ofs + 4'(i)));
      repeat (2) @(posedge sys_clk_in);
      #1 e = exp_spread(ofs + 4'(i));
      if (e[5]) chk(16'(spread_out), 16'(e));
      else chk(16'(spread_out.valid), 16'h0000);
    end
    wr(4'h1, 16'h0002);
    $display("test spread_codes done");
    pg <= 1'b1;
    lock_up();
    chk(16'(pll_locked_out), 16'h0001);
    watch(40);
    chk(16'(seen), 16'h01FF);
    rd(4'h2, rv);
    chk(rv, 16'h0022);
    for (int j = 0; j < 2; j++)
    begin
      oe = j ? 9'h155 : 9'($urandom);
      wr(4'h0, 16'(oe));
      repeat (20) @(posedge sys_clk_in);
      watch(48);
      chk(16'(seen), 16'(oe));
    end
    wr(4'h0, 16'h01FF);
    $display("test output_enables done");
    vid_stop <= 1'b1;
    repeat (40) @(posedge sys_clk_in);
    watch(48);
    chk(16'(seen), 16'h01F3);
    vid_stop <= 1'b0;
    watch(28);
    chk(16'(seen[3:2]), 16'h0003);
    $display("test video_stop done");
    // a two-cycle dip gives at most one low sample
    pd_req <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    pd_req <= 1'b0;
    repeat (40) @(posedge sys_clk_in);
    chk(16'(osc_on_out), 16'h0001);
    lag <= 8'($urandom % 16);
    power_down();
    chk(16'(osc_on_out), 16'h0000);
    chk({se_clk_out, diff_true_out, diff_comp_out}, 16'h0000);
    chk(16'(se_oe_out), 16'h000F);
    rd(4'h2, rv);
    chk(rv, 16'h0080);
    pd_req <= 1'b0;
    for (n = 0; n < 40 && diff_true_out !== 5'h1F; n++) @(posedge sys_clk_in);
    chk(16'(diff_true_out), 16'h001F);
    lock_up();
    chk(16'(pll_locked_out), 16'h0001);
    watch(40);
    chk(16'(seen), 16'h01FF);
    $display("test power_down done");
    reset(1'b1);
    repeat (3) @(posedge sys_clk_in);
    rd(4'h1, rv);
    chk(rv, 16'h0002);
    pg <= 1'b1;
    lock_up();
    power_down();
    chk(16'(se_oe_out), 16'h0000);
    chk({diff_true_out, diff_comp_out}, 16'h0000);
    rd(4'h2, rv);
    chk(rv, 16'h0084);
    $display("test strap_power_down done");
    end_of_test();
  end
endmodule
